/* slrb_pkg.sv */
// Constants, register map and state types of the front-panel supervisor.
// Assumes one free-running 100 MHz clock and a 32-bit AHB-Lite register bus.
// Operation
// [RULE1] Button holds count only while the selector is in halt.
// [RULE2] Under three seconds nothing; three to ten seconds blink red, reboot both engines.
// [RULE3] Over ten seconds red steady, factory restore clears data and both port setups.
// [RULE4] Processor lamps: off halted, green run, green blink locate, red error, both blink boot.
// [RULE5] I/O lamps: off unpowered, fast green stopped, green blink init, green working.
// [RULE6] I/O faults: init error, module alarm, comm fault, power or module overrun.
// [RULE7] Port one defaults to control program with lease, falls back to 0.0.0.0.
// [RULE8] Port two defaults to gateway with lease, falls back to 169.254.0.1.
// [RULE9] Button synchronised and debounced; hold timed press to release, acted on at release.
package slrb_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned REBOOT_HOLD_S = 3;
	localparam int unsigned RESTORE_HOLD_S = 10;
	localparam int unsigned DEBOUNCE_MS = 20;
	localparam int unsigned BLINK_SLOW_MS = 500;
	localparam int unsigned BLINK_FAST_MS = 125;
	localparam int unsigned REBOOT_CYC = REBOOT_HOLD_S * CLK_HZ;
	localparam int unsigned RESTORE_CYC = RESTORE_HOLD_S * CLK_HZ;
	localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
	localparam int unsigned BLINK_SLOW_CYC = BLINK_SLOW_MS * (CLK_HZ / 1000);
	localparam int unsigned BLINK_FAST_CYC = BLINK_FAST_MS * (CLK_HZ / 1000);

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
	localparam logic [7:0] ADDR_LEASE1 = 8'h10;
	localparam logic [7:0] ADDR_LEASE2 = 8'h14;
	localparam logic [7:0] ADDR_EFF1 = 8'h18;
	localparam logic [7:0] ADDR_EFF2 = 8'h1C;

	localparam int CPU_LSB = 0;
	localparam int IO_LSB = 4;
	localparam int LEASE1_OK_BIT = 8;
	localparam int LEASE2_OK_BIT = 9;
	localparam int ROLE1_GW_BIT = 12;
	localparam int ROLE2_CP_BIT = 13;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL_MASK = 32'h0000_3377;

	localparam int IRQ_REBOOT = 0;
	localparam int IRQ_RESTORE = 1;
	localparam int IRQ_IGNORED = 2;
	localparam int IRQ_W = 3;

	localparam logic [31:0] FALLBACK_ADDR1 = 32'h0000_0000;
	localparam logic [31:0] FALLBACK_ADDR2 = 32'hA9FE_0001;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	typedef enum logic [2:0] {
		SLRB_CPU_HALT = 3'b000,
		SLRB_CPU_RUN = 3'b001,
		SLRB_CPU_LOCATE = 3'b010,
		SLRB_CPU_ERROR = 3'b011,
		SLRB_CPU_BOOT = 3'b100
	} slrb_cpu_t;

	typedef enum logic [2:0] {
		SLRB_IO_OFF = 3'b000,
		SLRB_IO_STOPPED = 3'b001,
		SLRB_IO_INIT = 3'b010,
		SLRB_IO_WORKING = 3'b011,
		SLRB_IO_INIT_ERR = 3'b100,
		SLRB_IO_ALARM = 3'b101,
		SLRB_IO_COMM_FAULT = 3'b110,
		SLRB_IO_OVERRUN = 3'b111
	} slrb_io_t;

	typedef enum logic [1:0] {
		SLRB_IDLE = 2'b00,
		SLRB_HOLD = 2'b01,
		SLRB_IGNORE = 2'b10
	} slrb_hold_t;
endpackage

/* slrb_top.sv */
// Front-panel supervisor: button hold timing, lamp encoding, port fallback addresses.
// Assumes raw button and selector pins, and software on AHB-Lite feeding state codes.
//
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module slrb_top #(
	parameter logic [31:0] REBOOT_CYC = slrb_pkg::REBOOT_CYC,
	parameter logic [31:0] RESTORE_CYC = slrb_pkg::RESTORE_CYC,
	parameter logic [31:0] DEBOUNCE_CYC = slrb_pkg::DEBOUNCE_CYC,
	parameter logic [31:0] BLINK_SLOW_CYC = slrb_pkg::BLINK_SLOW_CYC,
	parameter logic [31:0] BLINK_FAST_CYC = slrb_pkg::BLINK_FAST_CYC
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Front panel pins
	input wire logic button_pin,
	input wire logic sel_run_pin,
	output logic cpu_green,
	output logic cpu_red,
	output logic io_green,
	output logic io_red,
	// System actions
	output logic reboot_pulse,
	output logic restore_pulse,
	output logic irq,
	// Network ports
	output logic eth1_gateway_role,
	output logic eth2_gateway_role,
	output logic [31:0] eth1_addr,
	output logic [31:0] eth2_addr
);
	logic btn_s1_q, btn_s2_q, sel_s1_q, sel_s2_q;
	logic [31:0] deb_cnt_q, deb_cnt_d;
	logic btn_db_q, btn_db_d;
	slrb_pkg::slrb_hold_t hold_st_q, hold_st_d;
	logic [31:0] hold_cnt_q, hold_cnt_d;
	logic reboot_q, reboot_d, restore_q, restore_d, ignored_d;
	logic [31:0] slow_cnt_q, slow_cnt_d, fast_cnt_q, fast_cnt_d;
	logic slow_q, slow_d, fast_q, fast_d;
	logic [31:0] ctrl_q, ctrl_d, lease1_q, lease1_d, lease2_q, lease2_d;
	logic [slrb_pkg::IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d, irq_set;
	logic cpu_g_d, cpu_r_d, io_g_d, io_r_d, cpu_g_q, cpu_r_q, io_g_q, io_r_q;
	logic [31:0] eff1_d, eff2_d, eff1_q, eff2_q;
	logic wr_q, wr_d;
	logic [7:0] wa_q, wa_d;
	logic [31:0] rdata_q, rdata_d;
	logic ap_take;
	logic [31:0] status_w;

	// Pins cross into hclk; only the second stage is read
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			btn_s1_q <= 1'b0;
			btn_s2_q <= 1'b0;
			sel_s1_q <= 1'b0;
			sel_s2_q <= 1'b0;
		end else begin
			btn_s1_q <= button_pin; // RULE9
			btn_s2_q <= btn_s1_q;
			sel_s1_q <= sel_run_pin;
			sel_s2_q <= sel_s1_q;
		end
	end

	// Debounce, hold timing, blink dividers
	always_comb begin
		deb_cnt_d = 32'h0000_0000;
		btn_db_d = btn_db_q;
		if (btn_s2_q != btn_db_q) begin
			if (deb_cnt_q == DEBOUNCE_CYC - 32'h0000_0001) begin
				btn_db_d = btn_s2_q; // RULE9
			end else begin
				deb_cnt_d = deb_cnt_q + 32'h0000_0001;
			end
		end
		hold_st_d = hold_st_q;
		hold_cnt_d = hold_cnt_q;
		reboot_d = 1'b0;
		restore_d = 1'b0;
		ignored_d = 1'b0;
		case (hold_st_q)
			slrb_pkg::SLRB_IDLE: begin
				hold_cnt_d = 32'h0000_0000;
				if (btn_db_q) begin
					if (sel_s2_q) begin
						hold_st_d = slrb_pkg::SLRB_IGNORE; // RULE1
						ignored_d = 1'b1;
					end else begin
						hold_st_d = slrb_pkg::SLRB_HOLD;
					end
				end
			end
			slrb_pkg::SLRB_HOLD: begin
				if (sel_s2_q) begin
					hold_st_d = slrb_pkg::SLRB_IGNORE; // RULE1
					ignored_d = 1'b1;
				end else if (!btn_db_q) begin
					hold_st_d = slrb_pkg::SLRB_IDLE; // RULE9
					if (hold_cnt_q >= RESTORE_CYC) begin
						restore_d = 1'b1; // RULE3
					end else if (hold_cnt_q >= REBOOT_CYC) begin
						reboot_d = 1'b1; // RULE2
					end
				end else if (hold_cnt_q < RESTORE_CYC) begin
					hold_cnt_d = hold_cnt_q + 32'h0000_0001;
				end
			end
			slrb_pkg::SLRB_IGNORE: begin
				hold_cnt_d = 32'h0000_0000;
				if (!btn_db_q) begin
					hold_st_d = slrb_pkg::SLRB_IDLE;
				end
			end
			default: begin
				hold_st_d = slrb_pkg::SLRB_IDLE;
				hold_cnt_d = 32'h0000_0000;
			end
		endcase
		slow_cnt_d = slow_cnt_q + 32'h0000_0001;
		slow_d = slow_q;
		if (slow_cnt_q >= BLINK_SLOW_CYC - 32'h0000_0001) begin
			slow_cnt_d = 32'h0000_0000;
			slow_d = !slow_q;
		end
		fast_cnt_d = fast_cnt_q + 32'h0000_0001;
		fast_d = fast_q;
		if (fast_cnt_q >= BLINK_FAST_CYC - 32'h0000_0001) begin
			fast_cnt_d = 32'h0000_0000;
			fast_d = !fast_q;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			deb_cnt_q <= 32'h0000_0000;
			btn_db_q <= 1'b0;
			hold_st_q <= slrb_pkg::SLRB_IDLE;
			hold_cnt_q <= 32'h0000_0000;
			reboot_q <= 1'b0;
			restore_q <= 1'b0;
			slow_cnt_q <= 32'h0000_0000;
			fast_cnt_q <= 32'h0000_0000;
			slow_q <= 1'b0;
			fast_q <= 1'b0;
		end else begin
			deb_cnt_q <= deb_cnt_d;
			btn_db_q <= btn_db_d;
			hold_st_q <= hold_st_d;
			hold_cnt_q <= hold_cnt_d;
			reboot_q <= reboot_d;
			restore_q <= restore_d;
			slow_cnt_q <= slow_cnt_d;
			fast_cnt_q <= fast_cnt_d;
			slow_q <= slow_d;
			fast_q <= fast_d;
		end
	end

	// Lamp encoding and port addresses
	always_comb begin
		cpu_g_d = 1'b0;
		cpu_r_d = 1'b0;
		case (ctrl_q[slrb_pkg::CPU_LSB +: 3])
			slrb_pkg::SLRB_CPU_RUN: cpu_g_d = 1'b1; // RULE4
			slrb_pkg::SLRB_CPU_LOCATE: cpu_g_d = slow_q; // RULE4
			slrb_pkg::SLRB_CPU_ERROR: cpu_r_d = 1'b1; // RULE4
			slrb_pkg::SLRB_CPU_BOOT: begin
				cpu_g_d = slow_q; // RULE4
				cpu_r_d = slow_q;
			end
			default: cpu_g_d = 1'b0;
		endcase
		// Hold feedback overrides the red lamp so the user knows when to let go
		if (hold_st_q == slrb_pkg::SLRB_HOLD) begin
			if (hold_cnt_q >= RESTORE_CYC) begin
				cpu_r_d = 1'b1; // RULE3
			end else if (hold_cnt_q >= REBOOT_CYC) begin
				cpu_r_d = slow_q; // RULE2
			end
		end
		io_g_d = 1'b0;
		io_r_d = 1'b0;
		case (ctrl_q[slrb_pkg::IO_LSB +: 3])
			slrb_pkg::SLRB_IO_STOPPED: io_g_d = fast_q; // RULE5
			slrb_pkg::SLRB_IO_INIT: io_g_d = slow_q; // RULE5
			slrb_pkg::SLRB_IO_WORKING: io_g_d = 1'b1; // RULE5
			slrb_pkg::SLRB_IO_INIT_ERR: begin
				io_g_d = slow_q; // RULE6
				io_r_d = 1'b1;
			end
			slrb_pkg::SLRB_IO_ALARM: begin
				io_g_d = 1'b1; // RULE6
				io_r_d = slow_q;
			end
			slrb_pkg::SLRB_IO_COMM_FAULT: begin
				io_g_d = 1'b1; // RULE6
				io_r_d = 1'b1;
			end
			slrb_pkg::SLRB_IO_OVERRUN: begin
				io_g_d = slow_q; // RULE6
				io_r_d = slow_q;
			end
			default: io_g_d = 1'b0;
		endcase
		eff1_d = ctrl_q[slrb_pkg::LEASE1_OK_BIT] ? lease1_q : slrb_pkg::FALLBACK_ADDR1; // RULE7
		eff2_d = ctrl_q[slrb_pkg::LEASE2_OK_BIT] ? lease2_q : slrb_pkg::FALLBACK_ADDR2; // RULE8
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpu_g_q <= 1'b0;
			cpu_r_q <= 1'b0;
			io_g_q <= 1'b0;
			io_r_q <= 1'b0;
			eff1_q <= slrb_pkg::FALLBACK_ADDR1;
			eff2_q <= slrb_pkg::FALLBACK_ADDR2;
		end else begin
			cpu_g_q <= cpu_g_d;
			cpu_r_q <= cpu_r_d;
			io_g_q <= io_g_d;
			io_r_q <= io_r_d;
			eff1_q <= eff1_d;
			eff2_q <= eff2_d;
		end
	end

	// Bus slave: zero wait states, reads fetched in the address phase
	assign ap_take = hsel && hready && htrans[1];
	assign status_w = {27'h000_0000, hold_st_q == slrb_pkg::SLRB_IGNORE,
		hold_st_q == slrb_pkg::SLRB_HOLD, sel_s2_q, btn_db_q, hold_cnt_q >= REBOOT_CYC};
	assign irq_set = {ignored_d, restore_d, reboot_d};

	always_comb begin
		wr_d = ap_take && hwrite && (hsize == slrb_pkg::HSIZE_WORD);
		wa_d = haddr[7:0];
		rdata_d = 32'h0000_0000;
		if (ap_take && !hwrite && (haddr[31:8] == 24'h00_0000)) begin
			case (haddr[7:0])
				slrb_pkg::ADDR_CTRL: rdata_d = ctrl_q;
				slrb_pkg::ADDR_STATUS: rdata_d = status_w;
				slrb_pkg::ADDR_IRQ_STAT: rdata_d = {29'h0000_0000, irq_stat_q};
				slrb_pkg::ADDR_IRQ_MASK: rdata_d = {29'h0000_0000, irq_mask_q};
				slrb_pkg::ADDR_LEASE1: rdata_d = lease1_q;
				slrb_pkg::ADDR_LEASE2: rdata_d = lease2_q;
				slrb_pkg::ADDR_EFF1: rdata_d = eff1_q;
				slrb_pkg::ADDR_EFF2: rdata_d = eff2_q;
				default: rdata_d = 32'h0000_0000;
			endcase
		end
		ctrl_d = ctrl_q;
		lease1_d = lease1_q;
		lease2_d = lease2_q;
		irq_mask_d = irq_mask_q;
		irq_stat_d = irq_stat_q;
		if (wr_q) begin
			case (wa_q)
				slrb_pkg::ADDR_CTRL: ctrl_d = hwdata & slrb_pkg::CTRL_MASK;
				slrb_pkg::ADDR_LEASE1: lease1_d = hwdata;
				slrb_pkg::ADDR_LEASE2: lease2_d = hwdata;
				slrb_pkg::ADDR_IRQ_MASK: irq_mask_d = hwdata[slrb_pkg::IRQ_W-1:0];
				slrb_pkg::ADDR_IRQ_STAT: irq_stat_d = irq_stat_q & ~hwdata[slrb_pkg::IRQ_W-1:0];
				default: ctrl_d = ctrl_q;
			endcase
		end
		// New events win over a clear in the same cycle
		irq_stat_d = irq_stat_d | irq_set;
		// Restore beats any software write to CTRL or a lease landing in the same cycle
		if (restore_q) begin
			ctrl_d = slrb_pkg::CTRL_RESET; // RULE3
			lease1_d = 32'h0000_0000;
			lease2_d = 32'h0000_0000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			wa_q <= 8'h00;
			rdata_q <= 32'h0000_0000;
			ctrl_q <= slrb_pkg::CTRL_RESET;
			lease1_q <= 32'h0000_0000;
			lease2_q <= 32'h0000_0000;
			irq_stat_q <= '0;
			irq_mask_q <= '0;
		end else begin
			wr_q <= wr_d;
			wa_q <= wa_d;
			rdata_q <= rdata_d;
			ctrl_q <= ctrl_d;
			lease1_q <= lease1_d;
			lease2_q <= lease2_d;
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_q;
	assign irq = |(irq_stat_q & irq_mask_q);
	assign cpu_green = cpu_g_q;
	assign cpu_red = cpu_r_q;
	assign io_green = io_g_q;
	assign io_red = io_r_q;
	assign reboot_pulse = reboot_q;
	assign restore_pulse = restore_q;
	assign eth1_gateway_role = ctrl_q[slrb_pkg::ROLE1_GW_BIT]; // RULE7
	assign eth2_gateway_role = !ctrl_q[slrb_pkg::ROLE2_CP_BIT]; // RULE8
	assign eth1_addr = eff1_q;
	assign eth2_addr = eff2_q;

	a_run_no_action: assert property (@(posedge hclk) disable iff (!hresetn) // RULE1
		(hold_st_q != slrb_pkg::SLRB_HOLD) |=> !reboot_q && !restore_q)
		else $error("action without a halt-position hold");
	a_short_hold_quiet: assert property (@(posedge hclk) disable iff (!hresetn) // RULE2
		(hold_st_q == slrb_pkg::SLRB_HOLD && !btn_db_q && !sel_s2_q && hold_cnt_q < REBOOT_CYC)
		|=> !reboot_q && !restore_q)
		else $error("short hold caused an action");
	a_mid_hold_reboot: assert property (@(posedge hclk) disable iff (!hresetn) // RULE2
		reboot_q |-> $past(hold_cnt_q) >= REBOOT_CYC && $past(hold_cnt_q) < RESTORE_CYC)
		else $error("reboot outside the reboot window");
	a_long_hold_red: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
		(hold_st_q == slrb_pkg::SLRB_HOLD && hold_cnt_q >= RESTORE_CYC) |=> cpu_red)
		else $error("red lamp not steady on long hold");
	a_restore_clears: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
		restore_q |=> ctrl_q == slrb_pkg::CTRL_RESET && lease1_q == 32'h0000_0000)
		else $error("restore left settings in place");
	a_cpu_run_lamp: assert property (@(posedge hclk) disable iff (!hresetn) // RULE4
		(ctrl_q[2:0] == slrb_pkg::SLRB_CPU_RUN && hold_st_q != slrb_pkg::SLRB_HOLD)
		|=> cpu_green && !cpu_red)
		else $error("run state lamps wrong");
	a_io_work_lamp: assert property (@(posedge hclk) disable iff (!hresetn) // RULE5
		(ctrl_q[6:4] == slrb_pkg::SLRB_IO_WORKING) |=> io_green && !io_red)
		else $error("io working lamps wrong");
	a_io_comm_lamp: assert property (@(posedge hclk) disable iff (!hresetn) // RULE6
		(ctrl_q[6:4] == slrb_pkg::SLRB_IO_COMM_FAULT) |=> io_green && io_red)
		else $error("io comm fault lamps wrong");
	a_eth1_fallback: assert property (@(posedge hclk) disable iff (!hresetn) // RULE7
		!ctrl_q[slrb_pkg::LEASE1_OK_BIT] |=> eth1_addr == slrb_pkg::FALLBACK_ADDR1)
		else $error("port one fallback address wrong");
	a_eth2_fallback: assert property (@(posedge hclk) disable iff (!hresetn) // RULE8
		!ctrl_q[slrb_pkg::LEASE2_OK_BIT] |=> eth2_addr == slrb_pkg::FALLBACK_ADDR2)
		else $error("port two fallback address wrong");
	a_debounce_wait: assert property (@(posedge hclk) disable iff (!hresetn) // RULE9
		$changed(btn_db_q) |-> $past(deb_cnt_q) == DEBOUNCE_CYC - 32'h0000_0001)
		else $error("debounced button changed early");
	c_reboot: cover property (@(posedge hclk) disable iff (!hresetn) reboot_q);
	c_restore: cover property (@(posedge hclk) disable iff (!hresetn) restore_q);
	c_ignored: cover property (@(posedge hclk) disable iff (!hresetn)
		hold_st_q == slrb_pkg::SLRB_IGNORE);
	c_irq: cover property (@(posedge hclk) disable iff (!hresetn) irq);
endmodule

/* slrb_panel_model.sv */
// Front-panel stand-in: drives the raw button and selector, watches the fault lamp.
// Assumes one caller at a time; every call starts and ends just after a rising edge.
`timescale 1ns/1ps
module slrb_panel_model (
	// Clock
	input wire logic hclk,
	// Lamp seen by the operator
	input wire logic cpu_red,
	// Raw panel pins
	output logic button_pin,
	output logic sel_run_pin
);
	int red_toggles;
	logic red_last;

	initial begin
		button_pin = 1'b0;
		sel_run_pin = 1'b0;
		red_toggles = 0;
		red_last = 1'b0;
	end

	// Contact bounce shorter than the debounce span at both ends of the press
	task automatic hold(input int n, input logic run);
		sel_run_pin <= run;
		@(posedge hclk);
		repeat (2) begin
			button_pin <= 1'b1;
			@(posedge hclk);
			button_pin <= 1'b0;
			@(posedge hclk);
		end
		button_pin <= 1'b1;
		repeat (n - 64) @(posedge hclk);
		red_toggles = 0;
		red_last = cpu_red;
		// Lamp judged only in the tail of the hold, its last 64 cycles
		repeat (64) begin
			@(posedge hclk);
			if (cpu_red !== red_last)
				red_toggles++;
			red_last = cpu_red;
		end
		button_pin <= 1'b0;
		@(posedge hclk);
		button_pin <= 1'b1;
		@(posedge hclk);
		button_pin <= 1'b0;
		repeat (12) @(posedge hclk);
		sel_run_pin <= 1'b0;
	endtask
endmodule

/* tb_status_led_and_reset_button.sv */
// Self-checking bench for the front-panel supervisor.
// Assumes shortened counts: reboot 300, restore 1000, debounce 4, blinks 8 and 2.
`timescale 1ns/1ps
module tb_status_led_and_reset_button;
	logic hclk, hresetn, hsel, hwrite, button_pin, sel_run_pin;
	logic [31:0] haddr, hwdata, hrdata, eth1_addr, eth2_addr, lease;
	logic [1:0] htrans;
	logic [2:0] hsize;
	wire logic hready;
	logic hreadyout, hresp, cpu_green, cpu_red, io_green, io_red;
	logic reboot_pulse, restore_pulse, irq, eth1_gateway_role, eth2_gateway_role;
	logic [7:0] code;
	logic [1:0] v;
	int miscompares, samples_checked, n_reboot, n_restore, n;

	assign hready = hreadyout;

	slrb_top #(.REBOOT_CYC(32'h12C), .RESTORE_CYC(32'h3E8), .DEBOUNCE_CYC(32'h4),
		.BLINK_SLOW_CYC(32'h8), .BLINK_FAST_CYC(32'h2)) i_slrb_top (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .button_pin(button_pin),
		.sel_run_pin(sel_run_pin), .cpu_green(cpu_green), .cpu_red(cpu_red),
		.io_green(io_green), .io_red(io_red), .reboot_pulse(reboot_pulse),
		.restore_pulse(restore_pulse), .irq(irq), .eth1_gateway_role(eth1_gateway_role),
		.eth2_gateway_role(eth2_gateway_role), .eth1_addr(eth1_addr), .eth2_addr(eth2_addr));

	slrb_panel_model i_slrb_panel_model (.hclk(hclk), .cpu_red(cpu_red),
		.button_pin(button_pin), .sel_run_pin(sel_run_pin));

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// Counting high cycles, so a stretched pulse also shows up
	always @(posedge hclk) begin
		if (reboot_pulse === 1'b1)
			n_reboot++;
		if (restore_pulse === 1'b1)
			n_restore++;
	end

	task automatic conclude;
		if (miscompares == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		logic rdy;
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		hsize <= slrb_pkg::HSIZE_WORD;
		// Ready and read data sampled mid-cycle, so the edge's own update cannot race them
		do begin
			@(negedge hclk);
			rdy = hreadyout;
			@(posedge hclk);
		end while (rdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(negedge hclk);
			rdy = hreadyout;
			r = hrdata;
			@(posedge hclk);
		end while (rdy !== 1'b1);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		check(r, exp);
	endtask

	function automatic logic [1:0] cls(input int t, input logic lvl);
		if (t >= 20)
			return 2'h3;
		if (t >= 3)
			return 2'h2;
		return {1'b0, lvl === 1'b1};
	endfunction

	// Per lamp: 0 off, 1 steady, 2 slow blink, 3 fast blink
	function automatic logic [7:0] lamp_exp(input int c, input int i);
		logic [3:0] cpu [5] = '{4'h0, 4'h4, 4'h8, 4'h1, 4'hA};
		logic [3:0] io [8] = '{4'h0, 4'hC, 4'h8, 4'h4, 4'h9, 4'h6, 4'h5, 4'hA};
		return {cpu[c], io[i]};
	endfunction

	task automatic observe(output logic [7:0] c);
		int t [4];
		logic [3:0] last, now;
		t = '{0, 0, 0, 0};
		last = {io_red, io_green, cpu_red, cpu_green};
		now = last;
		repeat (64) begin
			@(posedge hclk);
			now = {io_red, io_green, cpu_red, cpu_green};
			for (int k = 0; k < 4; k++)
				if (now[k] !== last[k])
					t[k]++;
			last = now;
		end
		c = {cls(t[0], now[0]), cls(t[1], now[1]), cls(t[2], now[2]), cls(t[3], now[3])};
	endtask

	initial begin
		#500000;
		miscompares++;
		conclude();
	end

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = 32'h0;
		miscompares = 0;
		samples_checked = 0;
		n_reboot = 0;
		n_restore = 0;
		void'($urandom(32'h80AC));
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		check(eth1_addr, slrb_pkg::FALLBACK_ADDR1);
		check(eth2_addr, slrb_pkg::FALLBACK_ADDR2);
		check({30'h0, eth1_gateway_role, eth2_gateway_role}, 32'h1);
		wr(slrb_pkg::ADDR_CTRL, 32'hFFFF_FFFF);
		rd(slrb_pkg::ADDR_CTRL, slrb_pkg::CTRL_MASK);
		rd(8'h20, 32'h0);
		// Lease answered or not, random lease values
		repeat (4) begin
			lease = $urandom;
			v = 2'($urandom);
			wr(slrb_pkg::ADDR_LEASE1, lease);
			wr(slrb_pkg::ADDR_LEASE2, ~lease);
			wr(slrb_pkg::ADDR_CTRL, {22'h0, v, 8'h0});
			repeat (2) @(posedge hclk);
			check(eth1_addr, v[0] ? lease : slrb_pkg::FALLBACK_ADDR1);
			check(eth2_addr, v[1] ? ~lease : slrb_pkg::FALLBACK_ADDR2);
			rd(slrb_pkg::ADDR_EFF2, v[1] ? ~lease : slrb_pkg::FALLBACK_ADDR2);
		end
		for (int k = 0; k < 8; k++) begin
			wr(slrb_pkg::ADDR_CTRL, {25'h0, 3'(k), 1'b0, 3'(k % 5)});
			repeat (4) @(posedge hclk);
			observe(code);
			check({24'h0, code}, {24'h0, lamp_exp(k % 5, k)});
		end
		wr(slrb_pkg::ADDR_IRQ_MASK, 32'h7);
		// Short, reboot, restore, then a long press in the run position
		for (int j = 0; j < 4; j++) begin
			n = (j == 0) ? 80 + $urandom % 170 : (j == 1) ? 400 + $urandom % 500 :
				1100 + $urandom % 400;
			wr(slrb_pkg::ADDR_CTRL, 32'h0000_3300);
			wr(slrb_pkg::ADDR_IRQ_STAT, 32'h7);
			n_reboot = 0;
			n_restore = 0;
			i_slrb_panel_model.hold(n, j == 3);
			check(cls(i_slrb_panel_model.red_toggles, i_slrb_panel_model.red_last),
				j == 1 ? 2 : j == 2 ? 1 : 0);
			repeat (8) @(posedge hclk);
			check(n_reboot, j == 1);
			check(n_restore, j == 2);
			rd(slrb_pkg::ADDR_IRQ_STAT, j == 3 ? 4 : j == 1 ? 1 : j == 2 ? 2 : 0);
			check(irq, j != 0);
			rd(slrb_pkg::ADDR_CTRL, j == 2 ? 0 : 32'h3300);
			check({30'h0, eth1_gateway_role, eth2_gateway_role}, j == 2 ? 1 : 2);
		end
		wr(slrb_pkg::ADDR_IRQ_MASK, 32'h3);
		@(negedge hclk);
		check(irq, 1'b0);
		@(posedge hclk);
		wr(slrb_pkg::ADDR_IRQ_MASK, 32'h7);
		@(negedge hclk);
		check(irq, 1'b1);
		@(posedge hclk);
		wr(slrb_pkg::ADDR_IRQ_STAT, 32'h4);
		@(posedge hclk);
		check(irq, 1'b0);
		conclude();
	end
endmodule
